// *** verilog/togc_pkg.sv ***
/*
 * Constants and types for the timer output shaping and global control block.
 * Assumes a 32-bit Avalon-MM slave window with byte addresses.
 */
`default_nettype none

package togc_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [2:0] TOGC_OFS_CTRL = 3'h0;
    localparam logic [2:0] TOGC_OFS_GCTRL = 3'h4;

    // ****************************************************************
    // Control register fields
    // ****************************************************************
    localparam int TOGC_CTL_STAT_LO = 0;
    localparam int TOGC_CTL_INVOUT_LO = 1;
    localparam int TOGC_CTL_LOW_INPUT_INVERT = 2;
    localparam int TOGC_CTL_LOW_CLOCK_PULSE_SELECT = 3;
    localparam int TOGC_CTL_PWID_LSB = 4;
    localparam int TOGC_CTL_PWID_MSB = 5;
    localparam int TOGC_CTL_LOW_CLOCK_SOURCE = 8;
    localparam int TOGC_CTL_STAT_HI = 16;
    localparam logic [31:0] TOGC_CTL_WMASK = 32'h0000013e;

    // ****************************************************************
    // Global control register fields
    // ****************************************************************
    localparam int TOGC_GCR_LORS = 0;
    localparam int TOGC_GCR_HIRS = 1;
    localparam int TOGC_GCR_MODE_LSB = 2;
    localparam int TOGC_GCR_MODE_MSB = 3;
    localparam int TOGC_GCR_PSC_LSB = 8;
    localparam int TOGC_GCR_PSC_MSB = 11;
    localparam int TOGC_GCR_DDR_LSB = 12;
    localparam int TOGC_GCR_DDR_MSB = 15;
    localparam logic [31:0] TOGC_GCR_WMASK = 32'h0000ff0f;
    localparam logic [31:0] TOGC_REG_RESET = 32'h00000000;

    // ****************************************************************
    // Misc constants
    // ****************************************************************
    localparam logic [1:0] TOGC_WIDTH_ZERO = 2'h0;
    localparam logic [1:0] TOGC_WIDTH_ONE = 2'h1;
    localparam logic [3:0] TOGC_PSC_ZERO = 4'h0;
    localparam logic [3:0] TOGC_PSC_ONE = 4'h1;

    typedef enum logic [1:0] {
        TOGC_MODE_GP64 = 2'b00,
        TOGC_MODE_UNCHAINED = 2'b01,
        TOGC_MODE_WATCHDOG = 2'b10,
        TOGC_MODE_CHAINED = 2'b11
    } togc_mode_e;

endpackage : togc_pkg

`default_nettype wire

// *** verilog/togc_top.sv ***
/*
 * Timer output shaping, input conditioning and global control registers,
 * with an Avalon-MM slave (one wait state) for host software.
 * Assumes the counters sit outside and report period matches as pulses,
 * and that all pin inputs are synchronous to clk_sys.
 */
// Design decisions made here: the Avalon-MM register port and the register offsets.
// Notes on behaviour
// - Width codes 10b, 11b give 3, 4 cycles
// - Width codes 00b, 01b give 1, 2 cycles
// - Watchdog mode forces pulse output
// - Pulse mode: one pulse per period match
// - Clock mode: toggle per match, square wave
// - External clock input optionally inverted
// - Output invert bit inverts timer output
// - Status bit 0 shows output, read-only
// - Output pin driven from status value
// - Prescale counter 15-12, period 11-8
// - Mode 3-2, upper reset 1, lower 0
// - Global fields reset zero, reserved read zero
// - Mode codes: gp64, unchained, watchdog, chained
// - Prescaler counts in unchained mode, tick after match, restarts
// - Upper reset clears upper status and stops upper tick
`timescale 1ns/1ps
`default_nettype none

module togc_top
    import togc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic low_period_match,
    input wire logic high_period_match,
    input wire logic low_timer_pin_in,
    output logic low_timer_pin_out,
    output logic low_timer_pin_oe,
    output logic low_count_tick,
    output logic upper_count_tick
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] togc_merge(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0] be,
        input logic [31:0] wmask
    );
        logic [31:0] lane;
        lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
        return (old_val & ~lane) | (new_val & lane);
    endfunction : togc_merge

    // ****************************************************************
    // State
    // ****************************************************************
    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_next;
    logic [31:0] gctrl_reg;
    logic [31:0] gctrl_next;
    logic waitrequest_reg;
    logic waitrequest_next;
    logic [31:0] readdata_reg;
    logic [31:0] readdata_next;
    logic raw_out_reg;
    logic raw_out_next;
    logic [1:0] width_cnt_reg;
    logic [1:0] width_cnt_next;
    logic low_status_reg;
    logic low_status_next;
    logic high_status_reg;
    logic high_status_next;
    logic pin_prev_reg;
    logic low_tick_reg;
    logic low_tick_next;
    logic upper_tick_reg;
    logic upper_tick_next;
    logic pin_oe_reg;
    logic pin_oe_next;

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    wire logic req = avs_read | avs_write;
    wire logic accept = req & waitrequest_reg;
    wire logic commit = avs_write & ~waitrequest_reg;
    wire logic hit_ctrl = (avs_address == TOGC_OFS_CTRL);
    wire logic hit_gctrl = (avs_address == TOGC_OFS_GCTRL);
    wire logic wr_ctrl = commit & hit_ctrl;
    wire logic wr_gctrl = commit & hit_gctrl;

    // ****************************************************************
    // Field views
    // ****************************************************************
    wire logic lo_rs = gctrl_reg[TOGC_GCR_LORS];
    wire logic hi_rs = gctrl_reg[TOGC_GCR_HIRS];
    wire logic [1:0] mode_bits = gctrl_reg[TOGC_GCR_MODE_MSB:TOGC_GCR_MODE_LSB];
    wire togc_mode_e op_mode = togc_mode_e'(mode_bits);
    wire logic [3:0] psc_period = gctrl_reg[TOGC_GCR_PSC_MSB:TOGC_GCR_PSC_LSB];
    wire logic [3:0] psc_count = gctrl_reg[TOGC_GCR_DDR_MSB:TOGC_GCR_DDR_LSB];
    wire logic inv_out = ctrl_reg[TOGC_CTL_INVOUT_LO];
    wire logic inv_inp = ctrl_reg[TOGC_CTL_LOW_INPUT_INVERT];
    wire logic clk_src = ctrl_reg[TOGC_CTL_LOW_CLOCK_SOURCE];
    wire logic [1:0] pwid = ctrl_reg[TOGC_CTL_PWID_MSB:TOGC_CTL_PWID_LSB];

    // Watchdog ignores the clock/pulse bit
    wire logic clock_mode = ctrl_reg[TOGC_CTL_LOW_CLOCK_PULSE_SELECT] & (op_mode != TOGC_MODE_WATCHDOG);

    // ****************************************************************
    // Read view
    // ****************************************************************
    // Status bits are injected here; stored copies of them are never used
    wire logic [31:0] ctrl_view = (ctrl_reg & TOGC_CTL_WMASK)
                                  | ({31'h0, low_status_reg} << TOGC_CTL_STAT_LO)
                                  | ({31'h0, high_status_reg} << TOGC_CTL_STAT_HI);
    wire logic [31:0] gctrl_view = gctrl_reg & TOGC_GCR_WMASK;

    always_comb begin
        readdata_next = readdata_reg;
        if (accept) begin
            readdata_next = TOGC_REG_RESET;
            if (hit_ctrl) begin
                readdata_next = ctrl_view;
            end else if (hit_gctrl) begin
                readdata_next = gctrl_view;
            end
        end
    end

    // One wait state, then waitrequest low for exactly one cycle
    assign waitrequest_next = ~accept;

    // ****************************************************************
    // Control register
    // ****************************************************************
    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl) begin
            // Status bits fall outside the write mask
            ctrl_next = togc_merge(ctrl_reg, avs_writedata, avs_byteenable,
                                   TOGC_CTL_WMASK);
        end
    end

    // ****************************************************************
    // Global control register and upper prescaler
    // ****************************************************************
    wire logic psc_run = (op_mode == TOGC_MODE_UNCHAINED) & hi_rs;
    wire logic psc_hit = psc_run & (psc_count == psc_period);
    wire logic [3:0] psc_count_next = psc_hit ? TOGC_PSC_ZERO
                                              : psc_count + TOGC_PSC_ONE;

    always_comb begin
        gctrl_next = gctrl_reg;
        if (psc_run) begin
            gctrl_next[TOGC_GCR_DDR_MSB:TOGC_GCR_DDR_LSB] = psc_count_next;
        end
        // A software write overrides the running prescale count
        if (wr_gctrl) begin
            gctrl_next = togc_merge(gctrl_reg, avs_writedata, avs_byteenable,
                                    TOGC_GCR_WMASK);
        end
    end

    // Upper counter advances the cycle after the match
    assign upper_tick_next = psc_hit;

    // ****************************************************************
    // Low output shaping
    // ****************************************************************
    always_comb begin
        raw_out_next = raw_out_reg;
        width_cnt_next = width_cnt_reg;
        if (!lo_rs) begin
            raw_out_next = 1'b0;
            width_cnt_next = TOGC_WIDTH_ZERO;
        end else if (clock_mode) begin
            width_cnt_next = TOGC_WIDTH_ZERO;
            if (low_period_match) begin
                raw_out_next = ~raw_out_reg;
            end
        end else if (low_period_match) begin
            // Remaining cycles after the first: 0..3 gives 1..4 wide
            raw_out_next = 1'b1;
            width_cnt_next = pwid;
        end else if (width_cnt_reg != TOGC_WIDTH_ZERO) begin
            width_cnt_next = width_cnt_reg - TOGC_WIDTH_ONE;
        end else begin
            raw_out_next = 1'b0;
        end
    end

    // Polarity applied after shaping so a flip takes effect at once
    assign low_status_next = lo_rs & (raw_out_next ^ inv_out);

    // ****************************************************************
    // High status
    // ****************************************************************
    // Upper output shaping lives elsewhere; only its reset hold is here
    assign high_status_next = hi_rs & high_period_match;

    // ****************************************************************
    // Input conditioning
    // ****************************************************************
    wire logic pin_cond = low_timer_pin_in ^ (clk_src & inv_inp);
    wire logic pin_rise = pin_cond & ~pin_prev_reg;
    // Internal source ticks every cycle; the invert bit is then unused
    assign low_tick_next = lo_rs & (clk_src ? pin_rise : 1'b1);

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ctrl_reg <= TOGC_REG_RESET;
            gctrl_reg <= TOGC_REG_RESET;
        end else if (clk_en) begin
            ctrl_reg <= ctrl_next;
            gctrl_reg <= gctrl_next;
        end
    end

    // Handshake freezes with clk_en, so a stalled bus keeps its wait state
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            waitrequest_reg <= 1'b1;
            readdata_reg <= TOGC_REG_RESET;
        end else if (clk_en) begin
            waitrequest_reg <= waitrequest_next;
            readdata_reg <= readdata_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            raw_out_reg <= 1'b0;
            width_cnt_reg <= TOGC_WIDTH_ZERO;
            low_status_reg <= 1'b0;
            high_status_reg <= 1'b0;
        end else if (clk_en) begin
            raw_out_reg <= raw_out_next;
            width_cnt_reg <= width_cnt_next;
            low_status_reg <= low_status_next;
            high_status_reg <= high_status_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pin_prev_reg <= 1'b0;
            low_tick_reg <= 1'b0;
            upper_tick_reg <= 1'b0;
        end else if (clk_en) begin
            pin_prev_reg <= pin_cond;
            low_tick_reg <= low_tick_next;
            upper_tick_reg <= upper_tick_next;
        end
    end

    // ****************************************************************
    // Pin direction
    // ****************************************************************
    // Taken from the next control value so the enable has no extra lag
    assign pin_oe_next = ~ctrl_next[TOGC_CTL_LOW_CLOCK_SOURCE];

    // Resets to driving, as the clock source bit resets to internal
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pin_oe_reg <= 1'b1;
        end else if (clk_en) begin
            pin_oe_reg <= pin_oe_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign avs_readdata = readdata_reg;
    assign avs_waitrequest = waitrequest_reg;
    // Pin carries the status value, inversion already included
    assign low_timer_pin_out = low_status_reg;
    // Pin is an output only while it is not the clock source
    assign low_timer_pin_oe = pin_oe_reg;
    assign low_count_tick = low_tick_reg;
    assign upper_count_tick = upper_tick_reg;

endmodule : togc_top

`default_nettype wire

// *** bench/togc_chk.sv ***
/* Port checker for togc_top.
   Assumes clk_en is held high and bound to every togc_top. */
`timescale 1ns/1ps
`default_nettype none
module togc_chk (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic [2:0] avs_address,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic low_period_match,
    input wire logic low_timer_pin_out,
    input wire logic low_timer_pin_oe,
    input wire logic low_count_tick,
    input wire logic upper_count_tick
);
    // ****************************************
    // Shadow of written settings
    // ****************************************
    logic [8:0] ctl_reg;
    logic [3:0] gcr_reg;
    wire logic wr_ok = avs_write && !avs_waitrequest;
    wire logic lors = gcr_reg[0];
    wire logic hirs = gcr_reg[1];
    wire logic src = ctl_reg[8];
    wire logic pmode = !ctl_reg[3] || gcr_reg[3:2] == 2'h2;
    wire logic pm = low_period_match && pmode && !ctl_reg[1] && lors;
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ctl_reg <= 9'h000;
            gcr_reg <= 4'h0;
        end else if (wr_ok && avs_address == 3'h0) begin
            ctl_reg[7:0] <= avs_byteenable[0] ? avs_writedata[7:0] : ctl_reg[7:0];
            ctl_reg[8] <= avs_byteenable[1] ? avs_writedata[8] : ctl_reg[8];
        end else if (wr_ok && avs_address == 3'h4 && avs_byteenable[0]) begin
            gcr_reg <= avs_writedata[3:0];
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("no answer one cycle after request");
    wait_drop_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    width_one_a: assert property (pm && ctl_reg[5:4] == 2'h0 ##1 !low_period_match[*1]
        |=> !low_timer_pin_out && $past(low_timer_pin_out)) else $error("pulse width 1 wrong");
    width_two_a: assert property (pm && ctl_reg[5:4] == 2'h1 ##1 !low_period_match[*2]
        |=> !low_timer_pin_out && $past(low_timer_pin_out) && $past(low_timer_pin_out, 2))
        else $error("pulse width 2 wrong");
    width_three_a: assert property (pm && ctl_reg[5:4] == 2'h2 ##1 !low_period_match[*3]
        |=> !low_timer_pin_out && $past(low_timer_pin_out) && $past(low_timer_pin_out, 3))
        else $error("pulse width 3 wrong");
    width_four_a: assert property (pm && ctl_reg[5:4] == 2'h3 ##1 !low_period_match[*4]
        |=> !low_timer_pin_out && $past(low_timer_pin_out) && $past(low_timer_pin_out, 4))
        else $error("pulse width 4 wrong");
    clock_toggle_a: assert property (low_period_match && !pmode && lors
        |=> low_timer_pin_out != $past(low_timer_pin_out)) else $error("no toggle on match");
    low_reset_a: assert property ($past(!lors) && !lors
        |-> !low_count_tick && !low_timer_pin_out) else $error("lower half active in reset");
    int_tick_a: assert property ($past(lors && !src) && lors && !src
        |-> low_count_tick) else $error("internal tick missing");
    high_reset_a: assert property ($past(!hirs) && !hirs |-> !upper_count_tick)
        else $error("upper tick while upper half in reset");
    pin_enable_a: assert property ($past(src) == src |-> low_timer_pin_oe == !src)
        else $error("pin enable not following clock source");
endmodule : togc_chk
bind togc_top togc_chk u_chk (.clk_sys, .reset_n, .avs_read, .avs_write, .avs_waitrequest,
    .avs_address, .avs_writedata, .avs_byteenable, .low_period_match, .low_timer_pin_out,
    .low_timer_pin_oe, .low_count_tick, .upper_count_tick);
`default_nettype wire

// *** bench/togc_far.sv ***
/* External counters and pin driver beside togc_top.
   Assumes the bench sets the match period and pin levels. */
`timescale 1ns/1ps
`default_nettype none
module togc_far (
    input wire logic clk_sys,
    input wire logic run,
    input wire logic [7:0] period,
    input wire logic hi_level,
    input wire logic pin_level,
    output logic low_period_match,
    output logic high_period_match,
    output logic pin_drive
);
    logic [7:0] cnt_reg = 8'h00;
    logic m_reg = 1'b0;
    logic h_reg = 1'b0;
    logic p_reg = 1'b0;
    assign low_period_match = m_reg;
    assign high_period_match = h_reg;
    assign pin_drive = p_reg;
    always @(posedge clk_sys) begin
        cnt_reg <= (!run || cnt_reg == period) ? 8'h00 : cnt_reg + 8'h01;
        m_reg <= run && cnt_reg == period;
        h_reg <= hi_level;
        p_reg <= pin_level;
    end
endmodule : togc_far
`default_nettype wire

// *** bench/tb.sv ***
/* Self-checking bench for togc_top.
   Assumes togc_chk and togc_far are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import togc_pkg::*;
    typedef struct {string what; logic [31:0] exp;} togc_note_s;
    togc_note_s notes[$];
    togc_note_s cur;
    logic clk_sys = 1'b0, reset_n = 1'b0, clk_en = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [2:0] avs_address = 3'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rnd = 32'h5b;
    logic [3:0] avs_byteenable = 4'hf;
    logic avs_waitrequest, low_period_match, high_period_match, pin_out, pin_oe, ltick, utick;
    logic far_pin, v, run = 1'b0, hi_lvl = 1'b0, pin_lvl = 1'b0;
    int num_errors = 0, checks = 0, cycles = 0, n;
    // Wire level: the design drives while its enable is high
    wire logic pin_wire = pin_oe ? pin_out : far_pin;
    togc_top uut (.clk_sys, .reset_n, .clk_en, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .low_period_match,
        .high_period_match, .low_timer_pin_in(pin_wire), .low_timer_pin_out(pin_out),
        .low_timer_pin_oe(pin_oe), .low_count_tick(ltick), .upper_count_tick(utick));
    togc_far far (.clk_sys, .run, .period(8'h08), .hi_level(hi_lvl), .pin_level(pin_lvl),
        .low_period_match, .high_period_match, .pin_drive(far_pin));
    always #2 clk_sys = ~clk_sys;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic finish_test;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk_sys);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic rd(input string what, input logic [2:0] a, input logic [31:0] e);
        notes.push_back('{what, e});
        bus(1'b0, a, 32'h0, 4'hf);
    endtask : rd
    task automatic pulse(input string what, input logic lvl, input int exp);
        n = 0;
        @(posedge clk_sys iff low_period_match === 1'b1);
        @(posedge clk_sys);
        while (pin_out === lvl) begin
            n++;
            @(posedge clk_sys);
        end
        check(what, 32'(n), 32'(exp));
    endtask : pulse
    task automatic edge_ticks(input logic [31:0] ctl, input int exp);
        n = 0;
        pin_lvl <= 1'b0;
        bus(1'b1, TOGC_OFS_CTRL, ctl, 4'hf);
        repeat (4) @(posedge clk_sys);
        pin_lvl <= 1'b1;
        repeat (6) begin
            @(posedge clk_sys);
            n += int'(ltick === 1'b1);
        end
        check("pin ticks", 32'(n), 32'(exp));
    endtask : edge_ticks
    // ****************************************
    // Read result monitor and hang guard
    // ****************************************
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            finish_test;
        end
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            cur = notes.pop_front();
            check(cur.what, avs_readdata, cur.exp);
        end
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd("control reset", TOGC_OFS_CTRL, 32'h0);
        rd("global reset", TOGC_OFS_GCTRL, 32'h0);
        for (int i = 0; i < 4; i++) begin
            rnd = xs(rnd);
            bus(1'b1, TOGC_OFS_GCTRL, rnd & 32'hfffffffc, 4'hf);
            rd("global fields", TOGC_OFS_GCTRL, rnd & 32'h0000ff0c);
        end
        rd("unmapped", 3'h2, 32'h0);
        bus(1'b1, TOGC_OFS_GCTRL, 32'h1, 4'hf);
        bus(1'b1, TOGC_OFS_CTRL, 32'hffffffff, 4'hf);
        rd("control fields", TOGC_OFS_CTRL, 32'h0000013f);
        bus(1'b1, TOGC_OFS_CTRL, 32'h0, 4'h1);
        rd("control lanes", TOGC_OFS_CTRL, 32'h00000100);
        edge_ticks(32'h100, 1);
        edge_ticks(32'h104, 0);
        run <= 1'b1;
        for (int w = 0; w < 4; w++) begin
            bus(1'b1, TOGC_OFS_CTRL, 32'(w) << 4, 4'hf);
            pulse("pulse width", 1'b1, w + 1);
        end
        bus(1'b1, TOGC_OFS_GCTRL, 32'h9, 4'hf);
        bus(1'b1, TOGC_OFS_CTRL, 32'h38, 4'hf);
        pulse("watchdog width", 1'b1, 4);
        bus(1'b1, TOGC_OFS_GCTRL, 32'h1, 4'hf);
        bus(1'b1, TOGC_OFS_CTRL, 32'h2, 4'hf);
        pulse("inverted pulse", 1'b0, 1);
        bus(1'b1, TOGC_OFS_CTRL, 32'h8, 4'hf);
        @(posedge clk_sys iff low_period_match === 1'b1);
        repeat (2) @(posedge clk_sys);
        v = pin_out;
        @(posedge clk_sys iff low_period_match === 1'b1);
        repeat (2) @(posedge clk_sys);
        check("clock toggle", 32'(pin_out), 32'(!v));
        run <= 1'b0;
        rd("status bit", TOGC_OFS_CTRL, 32'h8 | 32'(!v));
        bus(1'b1, TOGC_OFS_GCTRL, 32'h306, 4'hf);
        @(posedge clk_sys iff utick === 1'b1);
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (utick !== 1'b1);
        check("prescale spacing", 32'(n), 32'h4);
        hi_lvl <= 1'b1;
        bus(1'b1, TOGC_OFS_GCTRL, 32'h4, 4'hf);
        rd("upper status held", TOGC_OFS_CTRL, 32'h8);
        bus(1'b1, TOGC_OFS_GCTRL, 32'h6, 4'hf);
        rd("upper status", TOGC_OFS_CTRL, 32'h00010008);
        finish_test;
    end
endmodule : tb
`default_nettype wire
